//--- logic/interval_timer_pkg.sv
// Constants and mode encodings for the interval timer/counter.
// Assumes one core clock; the control word is presented as a plain input.
//
// Summary of operation
// - A 16-bit counter runs freely as an interval timer or event counter.
// - Asynchronous counter mode counts external edges without internal synchronisation.
// - When external sync is chosen, the synchroniser follows the prescaler.
// - Timer and gated timer modes count the internal instruction-cycle clock.
// - Both counter modes count the external count input pin.
// - Bit 1 of the control word selects internal or external clock source.
// - Bit 2 of the control word selects synchronisation of the external input.
// - Bit 6 of the control word enables gated accumulation with internal clock.
// - Mode decodes from source, gate and sync; irrelevant bits are ignored.
package interval_timer_pkg;

	localparam int CTRL_WIDTH   = 16;
	localparam int COUNT_WIDTH  = 16;
	localparam int PRESC_WIDTH  = 8;
	localparam int SRC_BIT      = 1;
	localparam int SYNC_BIT     = 2;
	localparam int GATE_BIT     = 6;
	localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 16'h0000;
	localparam logic [PRESC_WIDTH-1:0] PRESC_RESET = 8'h00;

	typedef enum logic [1:0] {
		MODE_TIMER = 2'b00,
		MODE_GATED = 2'b01,
		MODE_SYNC  = 2'b10,
		MODE_ASYNC = 2'b11
	} timer_mode_e;

endpackage

//--- logic/edge_sync.sv
// Two-flop synchroniser with a change pulse taken from the second stage.
// Assumes the input may change at any time relative to mclk, but holds each level two cycles or more.
`timescale 1ns/10ps
module edge_sync (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic resetn,
	// Level in, edge out
	input  wire logic levelIn,
	output logic      edgeOut
);
	logic stage1_r;
	logic stage2_r;
	logic stage3_r;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			stage1_r <= 1'b0;
			stage2_r <= 1'b0;
			stage3_r <= 1'b0;
		end else begin
			stage1_r <= levelIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
		end
	end

	assign edgeOut = stage2_r ^ stage3_r;
endmodule

//--- logic/interval_timer.sv
// Sixteen-bit interval timer/counter with four clocking modes.
// Assumes the instruction-cycle clock arrives as a one-cycle enable on mclk,
// and that the external count and gate pins are already synchronous to mclk.
// The control word, run enable and clear are plain level inputs.
`timescale 1ns/10ps
module interval_timer #(
	parameter int                     PRESC_W  = interval_timer_pkg::PRESC_WIDTH,
	parameter logic [PRESC_W-1:0]     PRESC_DIV = '0
) (
	// Clock and reset
	input  wire logic                                   mclk,
	input  wire logic                                   resetn,
	// Control
	input  wire logic [interval_timer_pkg::CTRL_WIDTH-1:0] timerControlWord,
	input  wire logic                                   timerOn,
	input  wire logic                                   counterClear,
	// Count sources
	input  wire logic                                   instructionCycleClock,
	input  wire logic                                   externalCountInput,
	input  wire logic                                   gateInput,
	// Status
	output logic [interval_timer_pkg::COUNT_WIDTH-1:0]  countValue,
	output logic [1:0]                                  activeMode
);

	// ----------------------------------------
	// Local widths
	// ----------------------------------------
	localparam int CNT_W = interval_timer_pkg::COUNT_WIDTH;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	// Only the three mode bits are looked at; the rest of the control word is
	// ignored, so unrelated settings may share it.
	function automatic interval_timer_pkg::timer_mode_e decode_mode(
		input logic src,
		input logic gate,
		input logic sync
	);
		interval_timer_pkg::timer_mode_e sel;
		sel = interval_timer_pkg::MODE_TIMER;
		unique case ({src, gate, sync})
			3'b000, 3'b001: sel = interval_timer_pkg::MODE_TIMER;
			3'b010, 3'b011: sel = interval_timer_pkg::MODE_GATED;
			3'b101, 3'b111: sel = interval_timer_pkg::MODE_SYNC;
			3'b100, 3'b110: sel = interval_timer_pkg::MODE_ASYNC;
		endcase
		return sel;
	endfunction

	function automatic logic is_rise(
		input logic cur,
		input logic prev
	);
		return cur & ~prev;
	endfunction

	function automatic logic is_toggle(
		input logic cur,
		input logic prev
	);
		return cur ^ prev;
	endfunction

	wire                             clockSourceSelect;
	wire                             externalSyncSelect;
	wire                             gateAccumulateEnable;
	interval_timer_pkg::timer_mode_e mode;

	assign clockSourceSelect    = timerControlWord[interval_timer_pkg::SRC_BIT];
	assign externalSyncSelect   = timerControlWord[interval_timer_pkg::SYNC_BIT];
	assign gateAccumulateEnable = timerControlWord[interval_timer_pkg::GATE_BIT];
	assign mode                 = decode_mode(clockSourceSelect, gateAccumulateEnable,
	                                          externalSyncSelect);

	// ----------------------------------------
	// External pin sampling
	// ----------------------------------------
	// The pin is taken as synchronous to mclk, so one register stage is enough
	// to find its rising edges.
	logic extSample_r;
	logic extPrev_r;
	wire  extRise;

	assign extRise = is_rise(extSample_r, extPrev_r);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			extSample_r <= 1'b0;
		end else begin
			extSample_r <= externalCountInput;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			extPrev_r <= 1'b0;
		end else begin
			extPrev_r <= extSample_r;
		end
	end

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	// The prescaler hands on a toggle rather than a pulse, so the synchroniser
	// after it sees a level that stands for a whole prescaled count.
	logic [PRESC_W-1:0] presc_r;
	logic [PRESC_W-1:0] presc_nxt;
	logic [PRESC_W-1:0] prescInc;
	logic               presOut_r;
	logic               presOut_nxt;
	wire                presWrap;
	wire                prescStep;

	assign presWrap    = (presc_r == PRESC_DIV);
	assign prescStep   = extRise & presWrap;
	assign prescInc    = presc_r + 1'b1;
	assign presc_nxt   = !extRise ? presc_r
	                   : (presWrap ? PRESC_W'(interval_timer_pkg::PRESC_RESET) : prescInc);
	assign presOut_nxt = prescStep ? ~presOut_r : presOut_r;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			presc_r <= PRESC_W'(interval_timer_pkg::PRESC_RESET);
		end else begin
			presc_r <= presc_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			presOut_r <= 1'b0;
		end else begin
			presOut_r <= presOut_nxt;
		end
	end

	// ----------------------------------------
	// Synchronous counter path
	// ----------------------------------------
	// The synchroniser sits behind the prescaler, so it carries one change per
	// prescaled count and costs two cycles of latency against the async path.
	wire syncTick;

	edge_sync u_sync (
		.mclk    (mclk),
		.resetn  (resetn),
		.levelIn (presOut_r),
		.edgeOut (syncTick)
	);

	// ----------------------------------------
	// Asynchronous counter path
	// ----------------------------------------
	// Each change of the prescaler toggle is one count; no synchroniser stands
	// in this path.
	logic presTogglePrev_r;
	wire  asyncTick;

	assign asyncTick = is_toggle(presOut_r, presTogglePrev_r);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			presTogglePrev_r <= 1'b0;
		end else begin
			presTogglePrev_r <= presOut_r;
		end
	end

	// ----------------------------------------
	// Count enable selection
	// ----------------------------------------
	wire timerTick;
	wire gatedTick;
	wire selTimer;
	wire selGated;
	wire selSync;
	wire selAsync;
	wire tick;

	assign timerTick = instructionCycleClock;
	assign gatedTick = instructionCycleClock & gateInput;

	assign selTimer  = (mode == interval_timer_pkg::MODE_TIMER);
	assign selGated  = (mode == interval_timer_pkg::MODE_GATED);
	assign selSync   = (mode == interval_timer_pkg::MODE_SYNC);
	assign selAsync  = (mode == interval_timer_pkg::MODE_ASYNC);
	assign tick      = (selTimer & timerTick)
	                 | (selGated & gatedTick)
	                 | (selSync  & syncTick)
	                 | (selAsync & asyncTick);

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// A clear wins over a count in the same cycle, and the count wraps from all
	// ones to zero with no flag, since no interrupt logic sits in this block.
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic [CNT_W-1:0] countInc;
	wire              countAdvance;

	assign countAdvance = timerOn & tick;
	assign countInc     = count_r + 1'b1;
	assign count_nxt    = counterClear ? interval_timer_pkg::COUNT_RESET
	                    : (countAdvance ? countInc : count_r);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			count_r <= interval_timer_pkg::COUNT_RESET;
		end else begin
			count_r <= count_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// The mode is shown straight from the decode, so a new control word is
	// visible in the same cycle.
	assign countValue = count_r;
	assign activeMode = mode;
endmodule

//--- tb/ext_source.sv
// Off-chip count source that sends the number of edges the bench asks for.
// Assumes the bench raises pulses by the count wanted.
`timescale 1ns/10ps
module ext_source (
	// Clock, reset and request
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic [7:0] pulses,
	// Count pin
	output logic            countPin
);
	logic [7:0] done_r;
	logic [1:0] ph_r;
	// Two cycles high and two low, so that no edge is lost or doubled.
	assign countPin = ph_r[1];
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			done_r <= 8'h00;
			ph_r   <= 2'h0;
		end else begin
			if (done_r != pulses || ph_r != 2'h0) ph_r <= ph_r + 2'h1;
			if (ph_r == 2'h3) done_r <= done_r + 8'h01;
		end
	end
endmodule

//--- tb/interval_timer_asserts.sv
// Port checks for the interval timer.
// Assumes a bind to interval_timer and one clock.
`timescale 1ns/10ps
module interval_timer_asserts (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        resetn,
	// Inputs
	input wire logic [15:0] timerControlWord,
	input wire logic        timerOn,
	input wire logic        counterClear,
	input wire logic        instructionCycleClock,
	input wire logic        externalCountInput,
	input wire logic        gateInput,
	// Outputs
	input wire logic [15:0] countValue,
	input wire logic [1:0]  activeMode
);
	wire logic [1:0] m = timerControlWord[1] ? {1'b1, !timerControlWord[2]} : {1'b0, timerControlWord[6]};
	wire logic       run = timerOn && !counterClear;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	timer_decode_a: assert property (m == 2'b00 |-> activeMode == 2'b00) else $error("decode");
	gated_decode_a: assert property (m == 2'b01 |-> activeMode == 2'b01) else $error("decode");
	sync_decode_a: assert property (m == 2'b10 |-> activeMode == 2'b10) else $error("decode");
	async_decode_a: assert property (m == 2'b11 |-> activeMode == 2'b11) else $error("decode");
	tick_count_a: assert property (run && instructionCycleClock && (m == 2'b00 || m == 2'b01 && gateInput)
		|=> countValue == $past(countValue) + 16'h0001) else $error("tick");
	gate_hold_a: assert property (m == 2'b01 && !gateInput && !counterClear |=> $stable(countValue)) else $error("gate");
	clear_zero_a: assert property (counterClear |=> countValue == 16'h0000) else $error("clear");
	async_count_a: assert property (m == 2'b11 && run && $rose(externalCountInput) |-> ##[1:5] $changed(countValue))
		else $error("async");
	sync_count_a: assert property (m == 2'b10 && run && $rose(externalCountInput) |-> ##[2:8] $changed(countValue))
		else $error("sync");
	cover property (m == 2'b01 && gateInput && instructionCycleClock && timerOn);
	cover property (counterClear);
	cover property (m[1] && $rose(externalCountInput));
endmodule
bind interval_timer interval_timer_asserts u_chk (.*);

//--- tb/testbench.sv
// Self-checking bench for the interval timer.
// Assumes ext_source supplies the count pin.
`timescale 1ns/10ps
module testbench;
	logic        mclk = 0, resetn = 0, on = 0, clr = 0, icc = 0, gate = 0, pin;
	logic [15:0] ctrl = 0, cnt, expCnt = 0;
	logic [1:0]  mode;
	logic [7:0]  pulses = 0, n;
	logic [31:0] seed = 32'h67204206;
	int          mismatches = 0, checked = 0, cycles = 0;
`define CHECK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; $display("FAIL %0t %h %h", $time, a, e); end end
	interval_timer u_interval_timer (.mclk, .resetn, .timerControlWord(ctrl), .timerOn(on), .counterClear(clr),
		.instructionCycleClock(icc), .externalCountInput(pin), .gateInput(gate), .countValue(cnt), .activeMode(mode));
	ext_source u_ext_source (.mclk, .resetn, .pulses, .countPin(pin));
	initial forever #2 mclk = ~mclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [1:0] modeOf(input logic [15:0] c);
		return c[1] ? {1'b1, !c[2]} : {1'b0, c[6]};
	endfunction
	task automatic finish_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge mclk) if (++cycles == 3000) begin mismatches++; finish_test(); end
	initial begin
		repeat (10) @(posedge mclk);
		resetn <= 1;
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			ctrl <= 16'(rnd()) & 16'hffb9 | {9'h0, i[2], 3'h0, i[1:0], 1'b0};
			@(negedge mclk);
			`CHECK(mode, modeOf(ctrl))
		end
		$display("decode done");
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			ctrl <= k ? 16'h0040 : 16'h0000;
			for (int j = 0; j < 300; j++) begin
				@(posedge mclk);
				if (icc && on && (!ctrl[6] || gate)) expCnt++;
				{icc, on, gate} <= 3'(rnd()) & {j < 299, 2'h3};
			end
			repeat (2) @(negedge mclk);
			`CHECK(cnt, expCnt)
		end
		$display("timer done");
		@(posedge mclk);
		{icc, on, clr} <= 3'h7;
		@(posedge mclk);
		{icc, clr} <= 2'h0;
		@(negedge mclk);
		`CHECK(cnt, 16'h0000)
		expCnt = 0;
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			n = 8'(rnd() % 8 + 1);
			ctrl <= k ? 16'h0046 : 16'h0002;
			on <= 1;
			pulses <= pulses + n;
			expCnt += 16'(n);
			repeat (45) @(negedge mclk);
			`CHECK(cnt, expCnt)
		end
		$display("counter done");
		finish_test();
	end
endmodule
